/* core/ufd_ctrl.sv */
// FIFO enable/clear, receive threshold and DMA request pins of one channel.
// Assumes channel strobes are synchronous to sys_clk; APB runs on sys_clk.
//
// Contract
// - Enable bit runs both FIFOs, else holding registers
// - Setup write without enable keeps other bits
// - Transmit clear empties count, bit self-clears
// - Receive clear empties count, bit self-clears
// - Threshold field maps to 1, 4, 8, 14
// - Receive interrupt at threshold, FIFO keeps filling
// - Mode bit selects DMA mode 0 or 1; mode 1 only while enable is set
// - Mode 0: transmit request low while empty
// - Mode 0: receive request low while data waits
// - Mode 1: transmit request high only when full
// - Mode 1: receive request low threshold/timeout until empty
// - Both modes set empty and threshold interrupt conditions
// - Bits 5:4 unused, held zero
// - Setup register resets to all zero
// - Receive interrupt clears below threshold
// - Empty interrupt cleared by status read or load
`default_nettype none
`include "ufd_consts.svh"

module ufd_ctrl (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire ufd_pkg::ufd_chan_ev_type chan_ev,
  output ufd_pkg::ufd_fifo_stat_type fifo_stat,
  output logic                       tx_dma_request_n,
  output logic                       rx_dma_request_n,
  output logic                       irq
);
  import ufd_pkg::*;

  ufd_state_type s;
  ufd_state_type n;
  logic          acc_wr;
  logic          acc_rd;
  logic          en_next;
  logic          mode1;
  logic [4:0]    tx_depth;
  logic [4:0]    rx_depth;
  logic [4:0]    thr_next;
  logic          tx_inc;
  logic          tx_dec;
  logic          rx_inc;
  logic          rx_dec;
  logic [2:0]    st_set;
  logic [2:0]    st_clr;

  function automatic logic [4:0] ufd_thr(input logic [1:0] f);
    unique case (f)
      2'b00: ufd_thr = `UFD_THR_01;
      2'b01: ufd_thr = `UFD_THR_04;
      2'b10: ufd_thr = `UFD_THR_08;
      2'b11: ufd_thr = `UFD_THR_14;
    endcase
  endfunction : ufd_thr

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = s;
    acc_wr   = psel & penable & s.pready & pwrite;
    acc_rd   = psel & penable & s.pready & ~pwrite;
    // Answer comes one cycle after setup, so outputs stay registered
    n.pready = psel & ~penable;
    n.fs.tx_fifo_clear = 1'b0;
    n.fs.rx_fifo_clear = 1'b0;
    st_clr   = 3'h0;

    if (psel & ~penable) begin
      n.pslverr = 1'b0;
      n.prdata  = 32'h0000_0000;
      unique case (paddr)
        `UFD_OFF_SETUP:  n.prdata = 32'h0000_0000;
        `UFD_OFF_STATUS: n.prdata = {29'h0000_0000, s.status};
        `UFD_OFF_MASK:   n.prdata = {29'h0000_0000, s.mask};
        `UFD_OFF_LIVE:   n.prdata = {16'h0000, s.tx_dma_request_n, s.rx_dma_request_n,
                                     s.setup[7:6], s.setup[3], s.setup[0],
                                     s.fs.rx_count, s.fs.tx_count};
        default:         n.pslverr = 1'b1;
      endcase
    end

    if (acc_wr && paddr == `UFD_OFF_SETUP) begin
      if (pwdata[`UFD_SET_EN]) begin
        // Bits 5:4 and the clear bits are never stored
        n.setup = {pwdata[7:6], 2'b00, pwdata[3], 3'b001};
        n.fs.tx_fifo_clear = pwdata[`UFD_SET_CLR_TX];
        n.fs.rx_fifo_clear = pwdata[`UFD_SET_CLR_RX];
      end else begin
        n.setup[`UFD_SET_EN] = 1'b0;
      end
      // Switching depth would strand entries, so both sides are wiped
      if (n.setup[`UFD_SET_EN] != s.setup[`UFD_SET_EN]) begin
        n.fs.tx_fifo_clear = 1'b1;
        n.fs.rx_fifo_clear = 1'b1;
      end
    end
    if (acc_wr && paddr == `UFD_OFF_MASK) begin
      n.mask = pwdata[2:0];
    end
    if (acc_rd && paddr == `UFD_OFF_STATUS) begin
      st_clr = s.prdata[2:0];
    end

    en_next    = n.setup[`UFD_SET_EN];
    n.fs.fifo_en = en_next;
    mode1    = en_next & n.setup[`UFD_SET_MODE];
    tx_depth = s.setup[`UFD_SET_EN] ? `UFD_DEPTH_FIFO : `UFD_DEPTH_HOLD;
    rx_depth = tx_depth;
    thr_next = en_next ? ufd_thr(n.setup[7:6]) : `UFD_THR_01;

    tx_inc = chan_ev.tx_load & (s.fs.tx_count != tx_depth);
    tx_dec = chan_ev.tx_unload & (s.fs.tx_count != 5'h00);
    rx_inc = chan_ev.rx_load & (s.fs.rx_count != rx_depth);
    rx_dec = chan_ev.rx_unload & (s.fs.rx_count != 5'h00);

    // Shift registers live outside; only counts and storage are wiped
    if (n.fs.tx_fifo_clear) begin
      n.fs.tx_count = 5'h00;
    end else begin
      n.fs.tx_count = s.fs.tx_count + {4'h0, tx_inc} - {4'h0, tx_dec};
    end
    if (n.fs.rx_fifo_clear) begin
      n.fs.rx_count = 5'h00;
    end else begin
      n.fs.rx_count = s.fs.rx_count + {4'h0, rx_inc} - {4'h0, rx_dec};
    end

    // Level interrupt follows the count both ways
    n.fs.rx_int = (n.fs.rx_count >= thr_next);

    if (mode1) begin
      n.tx_dma_request_n = (n.fs.tx_count == `UFD_DEPTH_FIFO);
      if (n.fs.rx_count == 5'h00) begin
        n.rx_dma_request_n = 1'b1;
      end else if (n.fs.rx_int | chan_ev.rx_timeout) begin
        n.rx_dma_request_n = 1'b0;
      end
    end else begin
      n.tx_dma_request_n = (n.fs.tx_count != 5'h00);
      n.rx_dma_request_n = (n.fs.rx_count == 5'h00);
    end

    st_set[`UFD_ST_TXE] = (s.fs.tx_count != 5'h00) & (n.fs.tx_count == 5'h00);
    st_set[`UFD_ST_RXT] = ~s.fs.rx_int & n.fs.rx_int;
    st_set[`UFD_ST_TMO] = chan_ev.rx_timeout & (s.fs.rx_count != 5'h00);
    st_clr[`UFD_ST_TXE] = st_clr[`UFD_ST_TXE] | tx_inc;
    st_clr[`UFD_ST_RXT] = st_clr[`UFD_ST_RXT] | ~n.fs.rx_int;
    // A new event beats a clear in the same cycle
    n.status = (s.status & ~st_clr) | st_set;
    n.fs.tx_empty_int = n.status[`UFD_ST_TXE];
    n.irq    = |(n.status & n.mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s.setup            <= `UFD_SET_RESET;
      s.fs               <= '0;
      s.tx_dma_request_n <= 1'b0;
      s.rx_dma_request_n <= 1'b1;
      s.status           <= `UFD_ST_RESET;
      s.mask             <= `UFD_MASK_RESET;
      s.irq              <= 1'b0;
      s.prdata           <= 32'h0000_0000;
      s.pready           <= 1'b0;
      s.pslverr          <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign fifo_stat        = s.fs;
  assign tx_dma_request_n = s.tx_dma_request_n;
  assign rx_dma_request_n = s.rx_dma_request_n;
  assign irq              = s.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic m1_now;
  logic set_wr;
  assign m1_now = s.setup[`UFD_SET_EN] & s.setup[`UFD_SET_MODE];
  assign set_wr = acc_wr && paddr == `UFD_OFF_SETUP;

  property p_hold_depth;
    !s.setup[0] && !set_wr |=> s.fs.tx_count <= 5'h01 && s.fs.rx_count <= 5'h01;
  endproperty
  a_hold_depth: assert property (p_hold_depth) else $error("holding depth exceeded");

  property p_keep_bits;
    set_wr && !pwdata[0] |=> !s.setup[0] && s.setup[7:1] == $past(s.setup[7:1]);
  endproperty
  a_keep_bits: assert property (p_keep_bits) else $error("setup bits changed");

  property p_tx_clear;
    set_wr && pwdata[0] && pwdata[2] |=> s.fs.tx_fifo_clear && s.fs.tx_count == 5'h00
      ##1 !s.fs.tx_fifo_clear;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx clear failed");

  property p_rx_clear;
    set_wr && pwdata[0] && pwdata[1] |=> s.fs.rx_fifo_clear && s.fs.rx_count == 5'h00
      ##1 !s.fs.rx_fifo_clear;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx clear failed");

  property p_thr14;
    s.setup[0] && s.setup[7:6] == 2'b11 |-> s.fs.rx_int == (s.fs.rx_count >= 5'd14);
  endproperty
  a_thr14: assert property (p_thr14) else $error("level 14 wrong");

  property p_thr4;
    s.setup[0] && s.setup[7:6] == 2'b01 |-> s.fs.rx_int == (s.fs.rx_count >= 5'd4);
  endproperty
  a_thr4: assert property (p_thr4) else $error("level 4 wrong");

  property p_rx_fill;
    s.setup[0] && chan_ev.rx_load && !chan_ev.rx_unload && !set_wr
      && s.fs.rx_count < 5'd16 |=> s.fs.rx_count == $past(s.fs.rx_count) + 5'd1;
  endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("rx fill stopped");

  property p_m0_pins;
    !m1_now |-> tx_dma_request_n == (s.fs.tx_count != 5'd0)
      && rx_dma_request_n == (s.fs.rx_count == 5'd0);
  endproperty
  a_m0_pins: assert property (p_m0_pins) else $error("mode 0 pins wrong");

  property p_m1_tx;
    m1_now |-> tx_dma_request_n == (s.fs.tx_count == 5'd16);
  endproperty
  a_m1_tx: assert property (p_m1_tx) else $error("mode 1 tx pin wrong");

  property p_m1_rx;
    m1_now |-> (s.fs.rx_count == 5'd0 ? rx_dma_request_n : (!s.fs.rx_int || !rx_dma_request_n));
  endproperty
  a_m1_rx: assert property (p_m1_rx) else $error("mode 1 rx pin wrong");

  property p_unused;
    s.setup[5:4] == 2'b00 && s.setup[2:1] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");

  property p_txe_set;
    s.fs.tx_count == 5'd1 && chan_ev.tx_unload && !chan_ev.tx_load && !set_wr
      |=> s.status[0] ##0 irq == s.mask[0] || irq;
  endproperty
  a_txe_set: assert property (p_txe_set) else $error("empty flag missed");

  //////////////////////////////////////////////////////////////////////////////
  // Level, pin and flag checks; writes excluded where setup may move
  property p_en_flag;
    s.fs.fifo_en == s.setup[0];
  endproperty
  a_en_flag: assert property (p_en_flag) else $error("enable flag wrong");

  property p_hold_thr;
    !s.setup[0] |-> s.fs.rx_int == (s.fs.rx_count != 5'd0);
  endproperty
  a_hold_thr: assert property (p_hold_thr) else $error("holding level wrong");

  property p_thr1;
    s.setup[0] && s.setup[7:6] == 2'b00 |-> s.fs.rx_int == (s.fs.rx_count >= 5'd1);
  endproperty
  a_thr1: assert property (p_thr1) else $error("level 1 wrong");

  property p_thr8;
    s.setup[0] && s.setup[7:6] == 2'b10 |-> s.fs.rx_int == (s.fs.rx_count >= 5'd8);
  endproperty
  a_thr8: assert property (p_thr8) else $error("level 8 wrong");

  property p_tx_clr_cnt;
    s.fs.tx_fifo_clear |-> s.fs.tx_count == 5'd0;
  endproperty
  a_tx_clr_cnt: assert property (p_tx_clr_cnt) else $error("tx count kept");

  property p_rx_clr_cnt;
    s.fs.rx_fifo_clear |-> s.fs.rx_count == 5'd0;
  endproperty
  a_rx_clr_cnt: assert property (p_rx_clr_cnt) else $error("rx count kept");

  property p_m0_tx_load;
    !m1_now && s.fs.tx_count == 5'd0 && chan_ev.tx_load && !chan_ev.tx_unload && !set_wr
      |=> tx_dma_request_n;
  endproperty
  a_m0_tx_load: assert property (p_m0_tx_load) else $error("tx pin stayed low");

  property p_m1_rx_tmo;
    m1_now && chan_ev.rx_timeout && s.fs.rx_count != 5'd0 && !chan_ev.rx_unload && !set_wr
      |=> !rx_dma_request_n;
  endproperty
  a_m1_rx_tmo: assert property (p_m1_rx_tmo) else $error("timeout ignored");

  property p_irq_lvl;
    irq == |(s.status & s.mask);
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq level wrong");

  property p_rx_int_fall;
    s.setup[0] && s.setup[7:6] == 2'b01 && s.fs.rx_count == 5'd4 && chan_ev.rx_unload
      && !chan_ev.rx_load && !set_wr |=> !s.fs.rx_int;
  endproperty
  a_rx_int_fall: assert property (p_rx_int_fall) else $error("rx level stuck");

  property p_rxt_clr;
    !s.fs.rx_int |-> !s.status[1];
  endproperty
  a_rxt_clr: assert property (p_rxt_clr) else $error("rx flag stuck");

  property p_txe_load;
    s.status[0] && chan_ev.tx_load && s.fs.tx_count == 5'd0 && !set_wr |=> !s.status[0];
  endproperty
  a_txe_load: assert property (p_txe_load) else $error("load kept empty flag");

  property p_txe_read;
    acc_rd && paddr == `UFD_OFF_STATUS && s.prdata[0] && s.fs.tx_count == 5'd0
      |=> !s.status[0];
  endproperty
  a_txe_read: assert property (p_txe_read) else $error("read kept empty flag");

  c_m1_burst: cover property (m1_now && !rx_dma_request_n ##[1:40] rx_dma_request_n);
  c_tx_full:  cover property (s.setup[0] && s.fs.tx_count == 5'd16);
  c_irq:      cover property ($rose(irq));
  c_tmo:      cover property (m1_now && chan_ev.rx_timeout && s.fs.rx_count != 5'd0);
  c_rx_clr:   cover property (s.fs.rx_fifo_clear);

endmodule : ufd_ctrl
`default_nettype wire

/* core/ufd_consts.svh */
// Offsets, field positions, reset values and levels of the FIFO/DMA control block.
// Assumes a 32-bit APB with an 8-bit byte address.
`ifndef UFD_CONSTS_SVH
`define UFD_CONSTS_SVH

// Register byte offsets
`define UFD_OFF_SETUP   8'h00
`define UFD_OFF_STATUS  8'h04
`define UFD_OFF_MASK    8'h08
`define UFD_OFF_LIVE    8'h0C

// fifo_setup_control fields
`define UFD_SET_EN      0
`define UFD_SET_CLR_RX  1
`define UFD_SET_CLR_TX  2
`define UFD_SET_MODE    3
`define UFD_SET_THR_LO  6
`define UFD_SET_THR_HI  7
`define UFD_SET_RESET   8'h00

// Status and mask fields
`define UFD_ST_TXE      0
`define UFD_ST_RXT      1
`define UFD_ST_TMO      2
`define UFD_ST_RESET    3'h0
`define UFD_MASK_RESET  3'h0

// Depths and receive levels
`define UFD_DEPTH_FIFO  5'h10
`define UFD_DEPTH_HOLD  5'h01
`define UFD_THR_01      5'h01
`define UFD_THR_04      5'h04
`define UFD_THR_08      5'h08
`define UFD_THR_14      5'h0E

`endif

/* core/ufd_pkg.sv */
// Types of the FIFO/DMA control block.
// Assumes ufd_consts.svh is on the include path.
`default_nettype none
package ufd_pkg;

  // Per-cycle strobes from the rest of the channel
  typedef struct packed {
    logic tx_load;
    logic tx_unload;
    logic rx_load;
    logic rx_unload;
    logic rx_timeout;
  } ufd_chan_ev_type;

  // Fill state presented back to the channel
  typedef struct packed {
    logic       fifo_en;
    logic       tx_fifo_clear;
    logic       rx_fifo_clear;
    logic [4:0] tx_count;
    logic [4:0] rx_count;
    logic       rx_int;
    logic       tx_empty_int;
  } ufd_fifo_stat_type;

  typedef struct packed {
    logic [7:0]        setup;
    ufd_fifo_stat_type fs;
    logic              tx_dma_request_n;
    logic              rx_dma_request_n;
    logic [2:0]        status;
    logic [2:0]        mask;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } ufd_state_type;

endpackage : ufd_pkg
`default_nettype wire

/* test/ufd_dma_model.sv */
// Far-side model: DMA controller plus the channel's line-side strobes.
// Assumes request pins and strobes share sys_clk with the block.
`default_nettype none
module ufd_dma_model (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    tx_dma_request_n,
  input  wire logic                    rx_dma_request_n,
  input  wire logic                    tx_go,
  input  wire logic                    rx_go,
  input  wire logic                    slow,
  input  wire logic [2:0]              line_ev,
  output var  ufd_pkg::ufd_chan_ev_type chan_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  import ufd_pkg::*;
  logic turn;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      turn <= 1'b0;
    end else begin
      turn <= !turn;
    end
  end
  // Prompt mode moves every cycle; pins change with the counts, so no move overshoots full or empty
  always_comb begin
    chan_ev.tx_load    = tx_go && !tx_dma_request_n && (!slow || turn);
    chan_ev.rx_unload  = rx_go && !rx_dma_request_n && (!slow || turn);
    chan_ev.tx_unload  = line_ev[2];
    chan_ev.rx_load    = line_ev[1];
    chan_ev.rx_timeout = line_ev[0];
  end
endmodule : ufd_dma_model
`default_nettype wire

/* test/ufd_ctrl_tb_top.sv */
// Bench for the FIFO/DMA control block: APB tasks and channel strobes.
// Assumes zero-wait APB and the model in ufd_dma_model.sv.
`default_nettype none
`include "ufd_consts.svh"
module ufd_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ufd_pkg::*;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_go = 0, rx_go = 0, slow = 0, err, pready, pslverr, txn, rxn, irq;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0]  line_ev = 0;
  ufd_chan_ev_type   ev;
  ufd_fifo_stat_type fs;
  logic [4:0] levels [4] = '{`UFD_THR_01, `UFD_THR_04, `UFD_THR_08, `UFD_THR_14};
  int n_mismatch = 0, samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  ufd_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_ev(ev), .fifo_stat(fs),
    .tx_dma_request_n(txn), .rx_dma_request_n(rxn), .irq(irq));
  ufd_dma_model u_dma (.sys_clk(sys_clk), .nrst(nrst), .tx_dma_request_n(txn),
    .rx_dma_request_n(rxn), .tx_go(tx_go), .rx_go(rx_go), .slow(slow),
    .line_ev(line_ev), .chan_ev(ev));
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    // A release just scheduled lets one edge pass before the next setup
    if (psel) @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  // One strobe per two cycles so every count settles before the next
  task automatic line(input logic [2:0] e, input int n);
    repeat (n) begin
      line_ev <= e;
      @(posedge sys_clk);
      line_ev <= 0;
      @(posedge sys_clk);
    end
  endtask : line
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(8);
    nrst <= 1;
    idle(1);
    apb(0, `UFD_OFF_LIVE, 0); chk(r, 32'h0000_4000);
    chk({txn, rxn, irq}, 3'h2);
    apb(0, 8'h10, 0); chk({err, r}, 33'h1_0000_0000);
    line(3'h2, 2); apb(0, `UFD_OFF_LIVE, 0); chk(r[9:5], 5'h01);
    chk(rxn, 1'b0);
    tx_go <= 1; idle(6); chk(txn, 1'b1);
    tx_go <= 0; line(3'h4, 1); chk(txn, 1'b0);
    rx_go <= 1; idle(4); chk(rxn, 1'b1);
    rx_go <= 0; $display("Test holding mode done");
    apb(1, `UFD_OFF_SETUP, 32'h0000_0049);
    idle(1); chk(fs.fifo_en, 1'b1);
    line(3'h2, 3); chk({rxn, fs.rx_int}, 2'h2);
    line(3'h2, 1); chk({rxn, fs.rx_int}, 2'h1);
    line(3'h2, 1); apb(0, `UFD_OFF_LIVE, 0); chk(r[9:5], 5'h05);
    apb(0, `UFD_OFF_STATUS, 0); chk(r[1], 1'b1);
    slow <= 1; rx_go <= 1;
    repeat (14) begin
      @(posedge sys_clk);
      chk(rxn, fs.rx_count == 5'h00);
      chk(fs.rx_int, fs.rx_count >= `UFD_THR_04);
    end
    slow <= 0; rx_go <= 0;
    line(3'h2, 1); chk(rxn, 1'b1);
    line(3'h1, 1); chk(rxn, 1'b0);
    apb(1, `UFD_OFF_SETUP, 32'h0000_004B); idle(2); chk({rxn, fs.rx_count}, 6'h20);
    tx_go <= 1; idle(40); chk({txn, fs.tx_count}, 6'h30);
    tx_go <= 0; line(3'h4, 1); chk({txn, fs.tx_count}, 6'h0F);
    $display("Test block mode done");
    apb(1, `UFD_OFF_MASK, 0); apb(0, `UFD_OFF_STATUS, 0);
    line(3'h4, 15); chk(irq, 1'b0);
    chk(fs.tx_empty_int, 1'b1);
    apb(1, `UFD_OFF_MASK, 1); apb(0, `UFD_OFF_MASK, 0); chk(r, 32'h0000_0001);
    idle(2); chk(irq, 1'b1);
    apb(0, `UFD_OFF_STATUS, 0); chk(r[0], 1'b1);
    idle(2); chk(irq, 1'b0);
    tx_go <= 1; idle(4); tx_go <= 0; line(3'h2, 1);
    apb(1, `UFD_OFF_SETUP, 32'h0000_004D); idle(2);
    chk({fs.tx_count, fs.rx_count}, 10'h001);
    $display("Test interrupt and clear done");
    for (int i = 0; i < 4; i++) begin
      apb(1, `UFD_OFF_SETUP, {24'h00_0000, i[1:0], 6'h03}); idle(2);
      line(3'h2, levels[i] - 1); chk(fs.rx_int, 1'b0);
      line(3'h2, 1); chk(fs.rx_int, 1'b1);
    end
    rx_go <= 1; idle(1); rx_go <= 0; idle(2); chk(fs.rx_int, 1'b0);
    apb(1, `UFD_OFF_SETUP, 32'h0000_0008); apb(0, `UFD_OFF_LIVE, 0);
    chk(r[13:10], 4'hC);
    $display("Test thresholds done");
    complete_run();
  end
  // Whole sequence runs well under 2000 cycles
  initial begin
    idle(20000);
    n_mismatch++;
    complete_run();
  end
endmodule : ufd_ctrl_tb_top
`default_nettype wire
